//--- hdl/adc_port_pkg.sv
/*
 Shared constants and carriers for the converter output port: register
 offsets, pipeline figures, code limits and the bus and pin structs.
 Assumes a single 40 MHz system clock and a 32-bit AXI4-Lite master.
*/
package adc_port_pkg;
   // Word and pipeline geometry.
   localparam int WORD_W = 12;
   localparam int SAMPLE_W = 14;
   localparam int STAGES = 10;
   localparam int HALF_EDGES = 17;
   localparam int PIPE_LAST = HALF_EDGES - 1;
   localparam int FINAL_SHIFT = STAGES - 1;
   // Code limits and stage thresholds, in output LSBs.
   localparam logic signed [13:0] FULL_POS = 14'sh07FF;
   localparam logic signed [13:0] FULL_NEG = 14'sh3800;
   localparam logic signed [13:0] STAGE_TH = 14'sh0200;
   localparam logic signed [13:0] STAGE_STEP = 14'sh0400;
   // Register byte offsets.
   localparam logic [5:0] OFF_CONTROL = 6'h00;
   localparam logic [5:0] OFF_RESULT = 6'h04;
   localparam logic [5:0] OFF_IRQ_STATUS = 6'h08;
   localparam logic [5:0] OFF_IRQ_MASK = 6'h0C;
   localparam logic [5:0] OFF_PINS = 6'h10;
   localparam logic [5:0] OFF_PERIOD = 6'h14;
   // Field positions and reset values.
   localparam int CTRL_SLEEP_BIT = 0;
   localparam int IRQ_NEW_BIT = 0;
   localparam int IRQ_OVR_BIT = 1;
   localparam int RESULT_OVR_BIT = 12;
   localparam logic [1:0] RST_IRQ_MASK = 2'h0;
   localparam logic RST_CTRL_SLEEP = 1'h0;
   localparam logic [15:0] PERIOD_MAX = 16'hFFFF;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // One entry of the half-cycle pipeline.
   typedef struct packed {
      logic ovr;
      logic signed [13:0] x;
      logic signed [13:0] res;
      logic signed [13:0] acc;
   } pipe_entry_s;

   // Master-driven AXI4-Lite signals.
   typedef struct packed {
      logic awvalid;
      logic [5:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [5:0] araddr;
      logic rready;
   } axi_in_s;

   // Slave-driven AXI4-Lite signals.
   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
   } axi_out_s;

   // Static and clock pins from outside the clock domain.
   typedef struct packed {
      logic clk_p;
      logic clk_n;
      logic clock_kind_select;
      logic code_format_select;
      logic duty_equalizer_enable;
      logic sleep_request;
   } pin_in_s;
endpackage : adc_port_pkg

//--- hdl/adc_output_port.sv
/*
 Digital side of a 12-bit pipelined converter: clock recovery from the
 conversion clock pins, a ten-stage redundant pipeline with error
 correction, output coding, range flag, valid strobe and AXI4-Lite
 registers with one interrupt. Assumes the sample bus and all pins come
 from outside aclk and that the sample is stable around the falling edge.
*/
// Decided for this implementation: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module adc_output_port
   import adc_port_pkg::*;
#(
   parameter logic signed [13:0] CMP_OFFSET = 14'sh0000
)
(
   input wire logic aclk, // System clock, 40 MHz.
   input wire logic aresetn, // Synchronous reset, active low.
   input wire axi_in_s axi_i, // Register bus from the master.
   output axi_out_s axi_o, // Register bus to the master.
   input wire pin_in_s pins, // Clock and static pins.
   input wire logic [13:0] analog_sample, // Digitised input level.
   output logic [11:0] conversion_word, // Result word.
   output logic over_range_flag, // Input beyond full scale.
   output logic sample_valid_strobe, // Data valid strobe.
   output logic irq // Level interrupt.
);

   typedef struct packed {
      pin_in_s pin_s1;
      pin_in_s pin_s2;
      logic [13:0] smp_s1;
      logic [13:0] smp_s2;
      logic level_q;
      logic [15:0] period_cnt;
      logic [15:0] period;
      pipe_entry_s [0:PIPE_LAST] pipe;
      logic [11:0] word;
      logic ovr_flag;
      logic strobe;
      logic ctrl_sleep;
      logic [1:0] irq_stat;
      logic [1:0] irq_mask;
      logic irq;
      axi_out_s bus;
      logic aw_have;
      logic w_have;
      logic [5:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
   } state_s;

   state_s st;
   state_s next_st;
   pipe_entry_s stage_out [1:PIPE_LAST];
   logic clk_level;
   logic rise;
   logic fall;
   logic asleep;
   logic word_load;
   logic signed [13:0] x_in;
   logic [11:0] bin;
   logic [1:0] irq_set;
   logic [1:0] irq_clr;
   logic [31:0] rd;
   logic [1:0] rd_resp;

   // Outputs are the state flip-flops themselves.
   assign axi_o = st.bus;
   assign conversion_word = st.word;
   assign over_range_flag = st.ovr_flag;
   assign sample_valid_strobe = st.strobe;
   assign irq = st.irq;

   // Each position of the chain advances one half cycle. The first nine
   // stages resolve a redundant digit and double the residue, the tenth
   // quantises what is left, the rest only delay the result. Overlapping
   // digit ranges let a comparator misplace its threshold without loss.
   generate
      for (genvar k = 1; k <= PIPE_LAST; k++)
      begin : g_stage
         if (k < STAGES)
         begin : g_resolve
            logic signed [1:0] d;
            assign d = (st.pipe[k-1].res > STAGE_TH + CMP_OFFSET) ? 2'sh1 :
               (st.pipe[k-1].res < CMP_OFFSET - STAGE_TH) ? 2'sh3 :
               2'sh0;
            assign stage_out[k].ovr = st.pipe[k-1].ovr;
            assign stage_out[k].x = st.pipe[k-1].x;
            assign stage_out[k].res =
               (st.pipe[k-1].res - d * STAGE_STEP) <<< 1;
            assign stage_out[k].acc =
               st.pipe[k-1].acc + d * (STAGE_STEP >>> (k - 1));
         end
         else if (k == STAGES)
         begin : g_last
            assign stage_out[k].ovr = st.pipe[k-1].ovr;
            assign stage_out[k].x = st.pipe[k-1].x;
            assign stage_out[k].res = 14'sh0000; // Last stage passes none.
            assign stage_out[k].acc = st.pipe[k-1].acc +
               (st.pipe[k-1].res >>> FINAL_SHIFT);
         end
         else
         begin : g_delay
            assign stage_out[k] = st.pipe[k-1];
         end
      end
   endgenerate

   // Recovered clock level, its edges and the power state.
   always_comb
   begin
      clk_level = st.pin_s2.clock_kind_select ?
         (st.pin_s2.clk_p & ~st.pin_s2.clk_n) :
         st.pin_s2.clk_p;
      rise = clk_level & ~st.level_q;
      fall = ~clk_level & st.level_q;
      asleep = st.pin_s2.sleep_request | st.ctrl_sleep;
      word_load = rise & ~asleep;
      x_in = st.smp_s2;
      bin = st.pipe[PIPE_LAST].acc[11:0];
   end

   // Register read decode; unmapped addresses answer with an error.
   always_comb
   begin
      rd = 32'h0000_0000;
      rd_resp = RESP_OKAY;
      case (axi_i.araddr)
         OFF_CONTROL: rd[CTRL_SLEEP_BIT] = st.ctrl_sleep;
         OFF_RESULT: rd[12:0] = {st.ovr_flag, st.word};
         OFF_IRQ_STATUS: rd[1:0] = st.irq_stat;
         OFF_IRQ_MASK: rd[1:0] = st.irq_mask;
         OFF_PINS: rd[4:0] = {asleep, st.pin_s2.sleep_request,
            st.pin_s2.duty_equalizer_enable,
            st.pin_s2.code_format_select,
            st.pin_s2.clock_kind_select};
         OFF_PERIOD: rd[15:0] = st.period;
         default: rd_resp = RESP_SLVERR;
      endcase
   end

   // Next state of the whole block.
   always_comb
   begin
      next_st = st;
      irq_clr = 2'h0;
      // Two flip-flops on everything that arrives from the pins.
      next_st.pin_s1 = pins;
      next_st.pin_s2 = st.pin_s1;
      next_st.smp_s1 = analog_sample;
      next_st.smp_s2 = st.smp_s1;
      next_st.level_q = clk_level;

      // Period of the conversion clock in system cycles.
      if (rise)
      begin
         next_st.period = st.period_cnt + 16'h0001;
         next_st.period_cnt = 16'h0000;
      end
      else if (st.period_cnt != PERIOD_MAX)
      begin
         next_st.period_cnt = st.period_cnt + 16'h0001;
      end

      // The chain moves on both edges and freezes while asleep.
      if (!asleep && (rise || fall))
      begin
         for (int i = 1; i <= PIPE_LAST; i++)
         begin
            next_st.pipe[i] = stage_out[i];
         end
         if (fall)
         begin
            next_st.pipe[0].ovr = (x_in > FULL_POS) ||
               (x_in < FULL_NEG);
            next_st.pipe[0].x = (x_in > FULL_POS) ? FULL_POS :
               (x_in < FULL_NEG) ? FULL_NEG : x_in;
            next_st.pipe[0].res = next_st.pipe[0].x;
            next_st.pipe[0].acc = 14'sh0000;
         end
      end

      // Output word on the rising edge that ends the 17th half cycle.
      if (asleep)
      begin
         next_st.word = 12'h000;
         next_st.ovr_flag = 1'b0;
      end
      else if (word_load)
      begin
         next_st.word = st.pin_s2.code_format_select ?
            (bin ^ (bin >> 1)) : bin;
         next_st.ovr_flag = st.pipe[PIPE_LAST].ovr;
      end

      // With the equalizer on, the strobe is rebuilt at half the measured
      // period, so a lopsided input clock still gives a square strobe.
      // The trade is one period of settling after the rate changes.
      if (asleep)
      begin
         next_st.strobe = 1'b0;
      end
      else if (st.pin_s2.duty_equalizer_enable)
      begin
         if (rise)
         begin
            next_st.strobe = 1'b1;
         end
         else if (st.period_cnt + 16'h0001 >= (st.period >> 1))
         begin
            next_st.strobe = 1'b0;
         end
      end
      else
      begin
         next_st.strobe = clk_level;
      end

      // Write channel capture; address and data may come in either order.
      if (axi_i.awvalid && st.bus.awready)
      begin
         next_st.aw_have = 1'b1;
         next_st.awaddr = axi_i.awaddr;
      end
      if (axi_i.wvalid && st.bus.wready)
      begin
         next_st.w_have = 1'b1;
         next_st.wdata = axi_i.wdata;
         next_st.wstrb = axi_i.wstrb;
      end
      if (st.bus.bvalid && axi_i.bready)
      begin
         next_st.bus.bvalid = 1'b0;
      end
      if (st.aw_have && st.w_have && !st.bus.bvalid)
      begin
         next_st.aw_have = 1'b0;
         next_st.w_have = 1'b0;
         next_st.bus.bvalid = 1'b1;
         next_st.bus.bresp = RESP_OKAY;
         case (st.awaddr)
            OFF_CONTROL:
               if (st.wstrb[0])
               begin
                  next_st.ctrl_sleep = st.wdata[CTRL_SLEEP_BIT];
               end
            OFF_IRQ_STATUS:
               if (st.wstrb[0])
               begin
                  irq_clr = st.wdata[1:0];
               end
            OFF_IRQ_MASK:
               if (st.wstrb[0])
               begin
                  next_st.irq_mask = st.wdata[1:0];
               end
            OFF_RESULT, OFF_PINS, OFF_PERIOD: ;
            default: next_st.bus.bresp = RESP_SLVERR;
         endcase
      end
      next_st.bus.awready = ~next_st.aw_have & ~next_st.bus.bvalid;
      next_st.bus.wready = ~next_st.w_have & ~next_st.bus.bvalid;

      // Read channel: one read at a time, answered the cycle after.
      if (axi_i.arvalid && st.bus.arready)
      begin
         next_st.bus.rvalid = 1'b1;
         next_st.bus.rdata = rd;
         next_st.bus.rresp = rd_resp;
      end
      else if (st.bus.rvalid && axi_i.rready)
      begin
         next_st.bus.rvalid = 1'b0;
      end
      next_st.bus.arready = ~next_st.bus.rvalid;

      // Sticky events; a new event beats a clear in the same cycle.
      irq_set[IRQ_NEW_BIT] = word_load;
      irq_set[IRQ_OVR_BIT] = word_load & st.pipe[PIPE_LAST].ovr;
      next_st.irq_stat = (st.irq_stat & ~irq_clr) | irq_set;
      next_st.irq = |(next_st.irq_stat & next_st.irq_mask);
   end

   // The single state register.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         st <= '0;
         st.irq_mask <= RST_IRQ_MASK;
         st.ctrl_sleep <= RST_CTRL_SLEEP;
      end
      else
      begin
         st <= next_st;
      end
   end

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   sequence seq_load_twos;
      word_load && !st.pin_s2.code_format_select;
   endsequence

   sequence seq_load_gray;
      word_load && st.pin_s2.code_format_select;
   endsequence

   sequence seq_asleep_twice;
      asleep ##1 asleep;
   endsequence

   AST_TWOS_FORMAT: assert property (
      seq_load_twos |=> conversion_word ==
         $past(st.pipe[PIPE_LAST].acc[11:0]))
      else $error("Two's complement word does not match the result.");

   AST_GRAY_FORMAT: assert property (
      seq_load_gray |=> (conversion_word ^ (conversion_word >> 1) ^
         (conversion_word >> 2) ^ (conversion_word >> 3) ^
         (conversion_word >> 4) ^ (conversion_word >> 5) ^
         (conversion_word >> 6) ^ (conversion_word >> 7) ^
         (conversion_word >> 8) ^ (conversion_word >> 9) ^
         (conversion_word >> 10) ^ (conversion_word >> 11)) ==
         $past(st.pipe[PIPE_LAST].acc[11:0]))
      else $error("Gray word does not decode to the result.");

   AST_RANGE_FLAG: assert property (
      fall && !asleep |=> st.pipe[0].ovr ==
         ($past(x_in) > FULL_POS || $past(x_in) < FULL_NEG))
      else $error("Range flag wrong for the captured sample.");

   AST_CORRECTION: assert property (
      st.pipe[STAGES].acc == st.pipe[STAGES].x)
      else $error("Corrected code differs from the sampled level.");

   AST_LOAD_ON_RISE: assert property (
      $changed(conversion_word) && !$past(asleep) |-> $past(rise))
      else $error("Word changed away from a rising clock edge.");

   AST_CAPTURE_FALL: assert property (
      $changed(st.pipe[0].x) |-> $past(fall) && !$past(asleep))
      else $error("Sample captured away from a falling edge.");

   AST_ADVANCE: assert property (
      (rise || fall) && !asleep |=> st.pipe[PIPE_LAST] ==
         $past(st.pipe[PIPE_LAST-1]))
      else $error("Pipeline did not advance on a half cycle.");

   AST_SLEEP: assert property (
      seq_asleep_twice |-> !sample_valid_strobe && conversion_word == 12'h000)
      else $error("Outputs active while asleep.");

   AST_STROBE_PLAIN: assert property (
      !asleep && !st.pin_s2.duty_equalizer_enable |=>
         sample_valid_strobe == $past(clk_level))
      else $error("Strobe does not follow the clock without equalizer.");

   AST_STROBE_EQ: assert property (
      rise && !asleep && st.pin_s2.duty_equalizer_enable |=>
         sample_valid_strobe)
      else $error("Equalized strobe did not rise with the clock.");

   AST_CLOCK_KIND: assert property (
      st.pin_s2.clock_kind_select && st.pin_s2.clk_n |-> !clk_level)
      else $error("Differential clock read high with its low leg high.");

endmodule : adc_output_port
`default_nettype wire

//--- sim/capture_backend.sv
/*
 Back-end capture model: latches the result word and range flag on each
 rising edge of the data valid strobe. Assumes it runs on aclk.
*/
`timescale 1ns/1ps
`default_nettype none
module capture_backend
(
   input wire logic aclk, // System clock.
   input wire logic strobe, // Data valid strobe.
   input wire logic [11:0] word, // Result word.
   input wire logic ovr, // Range flag.
   output logic [11:0] cap_word, // Latched word.
   output logic cap_ovr // Latched flag.
);
   logic last = 1'b0;

   // Latch only on the strobe's rise, as real capture flops would.
   always @(posedge aclk)
   begin
      last <= strobe;
      if (strobe && !last)
      begin
         cap_word <= word;
         cap_ovr <= ovr;
      end
   end
endmodule : capture_backend
`default_nettype wire

//--- sim/tb_top.sv
/*
 Testbench for the converter output port: bus tasks, conversion clock,
 code table, latency, strobe duty, sleep and interrupts. Assumes the
 package and the capture model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import adc_port_pkg::*;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   axi_in_s axi_i = '0;
   axi_out_s axi_o;
   pin_in_s pin_bus;
   logic clk_p = 1'b0;
   logic clk_n = 1'b0;
   logic kind_sel = 1'b0;
   logic fmt_sel = 1'b0;
   logic dce_en = 1'b0;
   logic sleep_req = 1'b0;
   logic [13:0] sample = 14'h0000;
   logic [11:0] word;
   logic [11:0] cap_word;
   logic ovr, cap_ovr, strobe, irq;
   logic [31:0] rd;
   logic [1:0] rsp;
   logic [12:0] ex;
   int div = 0;
   int hi_len = 4;
   int n_hi, n_lo, n;
   int n_mismatch = 0;
   int comparisons = 0;
   logic [13:0] codes [8] = '{14'h0000, 14'h0001, 14'h3FFF, 14'h07FF,
      14'h3800, 14'h0800, 14'h37FF, 14'h0555};

   assign pin_bus = {clk_p, clk_n, kind_sel, fmt_sel, dce_en, sleep_req};

   // System clock, 25 ns period.
   initial
   begin
      forever #12.5 aclk = ~aclk;
   end

   // Conversion clock of eight aclk periods; hi_len sets its duty cycle.
   always @(posedge aclk)
   begin
      div <= (div == 7) ? 0 : div + 1;
      clk_p <= (div < hi_len);
      clk_n <= kind_sel && !(div < hi_len);
   end

   // A nonzero offset proves the correction still yields exact codes.
   adc_output_port #(.CMP_OFFSET(14'sh0100)) u_adc_output_port (
      .aclk(aclk), .aresetn(aresetn), .axi_i(axi_i), .axi_o(axi_o),
      .pins(pin_bus), .analog_sample(sample), .conversion_word(word),
      .over_range_flag(ovr), .sample_valid_strobe(strobe), .irq(irq));

   capture_backend u_capture_backend (.aclk(aclk), .strobe(strobe),
      .word(word), .ovr(ovr), .cap_word(cap_word), .cap_ovr(cap_ovr));

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic check_in(input int v, input int lo, input int hi);
      comparisons++;
      if (v < lo || v > hi)
      begin
         n_mismatch++;
         $display("BAD %0t count %0d not in %0d..%0d", $time, v, lo, hi);
      end
   endtask : check_in

   task automatic wrap_up;
      $display("Mismatches %0d, comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : wrap_up

   // Saturated code and range flag; Gray is taken over the binary bits.
   function automatic logic [12:0] expect_code(input logic [13:0] v,
      input logic g);
      logic [11:0] b;
      logic o;
      o = ($signed(v) > FULL_POS) || ($signed(v) < FULL_NEG);
      b = o ? (v[13] ? 12'h800 : 12'h7FF) : v[11:0];
      if (g)
         b = b ^ (b >> 1);
      return {o, b};
   endfunction : expect_code

   // Handshakes are judged at the negedge, the values the next edge sees.
   task automatic axi_write(input logic [5:0] a, input logic [31:0] d,
      output logic [1:0] r);
      logic aw, w, b;
      int k;
      k = 0;
      axi_i.awaddr <= a;
      axi_i.wdata <= d;
      axi_i.wstrb <= 4'hF;
      axi_i.awvalid <= 1'b1;
      axi_i.wvalid <= 1'b1;
      axi_i.bready <= 1'b1;
      do
      begin
         @(negedge aclk);
         aw = axi_i.awvalid && axi_o.awready;
         w = axi_i.wvalid && axi_o.wready;
         b = axi_o.bvalid;
         r = axi_o.bresp;
         k++;
         @(posedge aclk);
         if (aw)
            axi_i.awvalid <= 1'b0;
         if (w)
            axi_i.wvalid <= 1'b0;
      end
      while (!b);
      axi_i.bready <= 1'b0;
      @(posedge aclk);
   endtask : axi_write

   task automatic axi_read(input logic [5:0] a, output logic [31:0] d,
      output logic [1:0] r);
      logic ar, v;
      int k;
      k = 0;
      axi_i.araddr <= a;
      axi_i.arvalid <= 1'b1;
      axi_i.rready <= 1'b1;
      do
      begin
         @(negedge aclk);
         ar = axi_i.arvalid && axi_o.arready;
         v = axi_o.rvalid;
         d = axi_o.rdata;
         r = axi_o.rresp;
         k++;
         @(posedge aclk);
         if (ar)
            axi_i.arvalid <= 1'b0;
      end
      while (!v);
      axi_i.rready <= 1'b0;
      @(posedge aclk);
   endtask : axi_read

   task automatic settle(input int k);
      repeat (k * 8) @(posedge aclk);
   endtask : settle

   // Measures one high and one low phase of the strobe in aclk cycles.
   task automatic duty;
      @(negedge aclk);
      while (strobe === 1'b1) @(negedge aclk);
      while (strobe !== 1'b1) @(negedge aclk);
      for (n_hi = 0; strobe === 1'b1 && n_hi < 40; n_hi++) @(negedge aclk);
      for (n_lo = 0; strobe !== 1'b1 && n_lo < 40; n_lo++) @(negedge aclk);
      @(posedge aclk);
   endtask : duty

   // Main sequence.
   initial
   begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (4) @(posedge aclk);
      axi_read(OFF_CONTROL, rd, rsp);
      check(rd, 32'h0);
      axi_read(OFF_IRQ_MASK, rd, rsp);
      check(rd, 32'(RST_IRQ_MASK));
      axi_read(6'h18, rd, rsp);
      check(32'(rsp), 32'(RESP_SLVERR));
      axi_write(6'h18, 32'h1, rsp);
      check(32'(rsp), 32'(RESP_SLVERR));
      // Code table over both clock kinds and both output formats.
      for (int k = 0; k < 4; k++)
      begin
         kind_sel <= k[1];
         fmt_sel <= k[0];
         foreach (codes[i])
         begin
            sample <= codes[i];
            settle(12);
            ex = expect_code(codes[i], k[0]);
            check(32'(word), 32'(ex[11:0]));
            check(32'(ovr), 32'(ex[12]));
            check(32'(cap_word), 32'(ex[11:0]));
            axi_read(OFF_RESULT, rd, rsp);
            check(rd, 32'(ex));
         end
      end
      // Latency: change the sample at a clock rise, before its fall.
      kind_sel <= 1'b0;
      fmt_sel <= 1'b0;
      sample <= 14'h0000;
      settle(12);
      @(negedge aclk);
      while (div != 0) @(negedge aclk);
      @(posedge aclk);
      sample <= 14'h0123;
      for (n = 0; word !== 12'h123 && n < 200; n++) @(negedge aclk);
      check_in(n, 71, 81);
      // A 25 percent duty clock, with and without the equalizer.
      hi_len = 2;
      for (int e = 0; e < 2; e++)
      begin
         dce_en <= e[0];
         settle(6);
         duty();
         check_in(n_hi + n_lo, 8, 8);
         check_in(n_hi, e ? 3 : 2, e ? 5 : 2);
      end
      // The measured period is the bench's eight aclk conversion clock.
      axi_read(OFF_PERIOD, rd, rsp);
      check(rd, 32'h0000_0008);
      hi_len = 4;
      // Sleep from the pin, then from the control register.
      for (int s = 0; s < 2; s++)
      begin
         sleep_req <= !s[0];
         if (s == 1)
            axi_write(OFF_CONTROL, 32'h1, rsp);
         settle(4);
         n = 0;
         repeat (32)
         begin
            @(negedge aclk);
            if (strobe !== 1'b0)
               n++;
         end
         check_in(n, 0, 0);
         check(32'({word, ovr}), 32'h0);
         axi_read(OFF_PINS, rd, rsp);
         check(32'(rd[4]), 32'h1);
      end
      // Interrupts: cleared while frozen, raised on wake, then masked.
      axi_write(OFF_IRQ_STATUS, 32'h3, rsp);
      axi_write(OFF_IRQ_MASK, 32'h1, rsp);
      axi_read(OFF_IRQ_STATUS, rd, rsp);
      check(rd, 32'h0);
      check(32'(irq), 32'h0);
      sample <= 14'h0800;
      axi_write(OFF_CONTROL, 32'h0, rsp);
      settle(12);
      check(32'(irq), 32'h1);
      axi_read(OFF_IRQ_STATUS, rd, rsp);
      check(rd, 32'h3);
      axi_write(OFF_IRQ_MASK, 32'h0, rsp);
      repeat (2) @(posedge aclk);
      check(32'(irq), 32'h0);
      wrap_up();
   end

   // Cuts a hang short; the tests need about 4000 aclk cycles.
   initial
   begin
      repeat (20000) @(posedge aclk);
      n_mismatch++;
      wrap_up();
   end
endmodule : tb_top
`default_nettype wire
